// ==== shared/qdlc_pkg.sv ====
// constants, types and helpers shared by the quad converter load control
package qdlc_pkg;
    localparam int CHANNELS    = 4;
    localparam int DATA_W      = 16;
    localparam int CAL_W       = 8;
    localparam int WORD_BITS   = 24;
    localparam int CNT_W       = 5;
    localparam int ADDR_LSB    = 16;
    localparam int ADDR_W      = 4;
    // control word field positions
    localparam int CTRL_GAIN_LSB = 0;
    localparam int CTRL_PD_LSB   = 4;
    localparam int CTRL_GPIO_LSB = 8;
    // address map of the command word
    localparam logic [3:0] ADDR_CTRL      = 4'h0;
    localparam logic [3:0] ADDR_DATA_BASE = 4'h4;
    localparam logic [3:0] ADDR_ZERO_BASE = 4'h8;
    localparam logic [3:0] ADDR_GAIN_BASE = 4'hC;
    // reset values and the bipolar sign-flip mask
    localparam logic [15:0] CODE_RST     = 16'h0000;
    localparam logic [15:0] BIPOLAR_FLIP = 16'h8000;
    localparam logic [7:0]  ZERO_CAL_RST = 8'h00;
    localparam logic [7:0]  GAIN_CAL_RST = 8'h80;
    localparam logic [3:0]  GAIN_SEL_RST = 4'hF;
    localparam logic [3:0]  PD_RST       = 4'h0;
    localparam logic [1:0]  GPIO_REL_RST = 2'h3;
    localparam logic [8:0]  PIN_SYNC_RST = 9'h1FB; // serial clock parks high between frames
    // timing
    localparam int CLK_PERIOD_NS   = 4;
    localparam int PD_RECOVERY_US  = 50;
    localparam int PD_RECOVERY_CYC = (PD_RECOVERY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // per-channel view handed to the analog side
    typedef struct packed {
        logic [DATA_W-1:0] code;
        logic [CAL_W-1:0]  zero_cal;
        logic [CAL_W-1:0]  gain_cal;
        logic              gain_high;
        logic              powered;
    } qdlc_chan_t;

    // ladder code: unipolar passes straight binary, bipolar flips sign bit
    function automatic logic [DATA_W-1:0] to_ladder(input logic [DATA_W-1:0] code,
                                                    input logic unipolar);
        to_ladder = unipolar ? code : (code ^ BIPOLAR_FLIP);
    endfunction : to_ladder
endpackage : qdlc_pkg

// ==== rtl/qdlc_sync2.sv ====
// two-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
module qdlc_sync2 #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;

    // first stage is read only by the second
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_reg <= RST_VAL;
            q_reg    <= RST_VAL;
        end else begin
            meta_reg <= d_i;
            q_reg    <= meta_reg;
        end
    end

    assign q_o = q_reg;
endmodule : qdlc_sync2

// ==== rtl/qdlc_pd_timer.sv ====
// power-down recovery timer for one channel
`timescale 1ns/1ps
module qdlc_pd_timer #(
    parameter int CYCLES = 12500
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic pd_i,
    output logic      ready_o
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic          ready_reg;
    logic          ready_next;

    // power-down drops ready at once; release waits the full recovery time
    always_comb begin
        cnt_next   = cnt_reg;
        ready_next = ready_reg;
        if (pd_i) begin
            cnt_next   = '0;
            ready_next = 1'b0;
        end else if (!ready_reg) begin
            if (cnt_reg == LAST) begin
                ready_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg   <= '0;
            ready_reg <= 1'b1;
        end else begin
            cnt_reg   <= cnt_next;
            ready_reg <= ready_next;
        end
    end

    assign ready_o = ready_reg;

    a_pd_recovery_time: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(ready_o) |-> ($past(cnt_reg) == LAST) && $past(!pd_i))
        else $error("channel ready before recovery time elapsed");
endmodule : qdlc_pd_timer

// ==== rtl/qdlc_top.sv ====
// quad converter load control: serial word intake, input registers, output latches
`timescale 1ns/1ps
module qdlc_top #(
    parameter int PD_RECOVERY_CYCLES = qdlc_pkg::PD_RECOVERY_CYC
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   cs_n_i,
    input  wire logic                   sclk_i,
    input  wire logic                   sdi_i,
    output logic                        sdo_o,
    output logic                        sdo_oe_o,
    input  wire logic                   latch_load_n_i,
    input  wire logic                   dev_reset_n_i,
    input  wire logic                   polarity_select_group_a_i,
    input  wire logic                   polarity_select_group_b_i,
    input  wire logic [1:0]             gpio_i,
    output logic      [1:0]             gpio_o,
    output logic      [1:0]             gpio_oe_o,
    output logic      [1:0]             gpio_level_o,
    output qdlc_pkg::qdlc_chan_t [3:0]  chan_o
);
    localparam int N = qdlc_pkg::CHANNELS;
    localparam int W = qdlc_pkg::DATA_W;
    localparam int C = qdlc_pkg::CAL_W;
    localparam logic [qdlc_pkg::CNT_W-1:0] FULL = qdlc_pkg::CNT_W'(qdlc_pkg::WORD_BITS);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // synchronised pin levels
    logic [8:0] pins_s;
    logic       cs_n_s;
    logic       sclk_s;
    logic       sdi_s;
    logic       latch_load_n_n_s;
    logic       dev_rst_n_s;
    logic       pol_a_s;
    logic       pol_b_s;
    logic [1:0] gpio_s;

    // every pin, serial clock included, passes two flops before use
    qdlc_sync2 #(
        .W       (9),
        .RST_VAL (qdlc_pkg::PIN_SYNC_RST)
    ) u_pin_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     ({gpio_i, polarity_select_group_b_i, polarity_select_group_a_i,
                   dev_reset_n_i, latch_load_n_i, sdi_i, sclk_i, cs_n_i}),
        .q_o     (pins_s)
    );

    assign {gpio_s, pol_b_s, pol_a_s, dev_rst_n_s, latch_load_n_n_s, sdi_s, sclk_s, cs_n_s} = pins_s;

    // serial framing state
    logic [qdlc_pkg::WORD_BITS-1:0] shift_reg;
    logic [qdlc_pkg::WORD_BITS-1:0] shift_next;
    logic [qdlc_pkg::CNT_W-1:0]     cnt_reg;
    logic [qdlc_pkg::CNT_W-1:0]     cnt_next;
    logic                           sclk_prev_reg;
    logic                           cs_prev_reg;
    logic                           sdo_reg;
    logic                           sdo_next;
    logic                           sdo_oe_reg;
    logic                           sclk_fall;
    logic                           sclk_rise;
    logic                           cs_fall;
    logic                           commit;
    logic [qdlc_pkg::ADDR_W-1:0]    waddr;
    logic [W-1:0]                   wdata;

    assign sclk_fall = sclk_prev_reg & ~sclk_s;
    assign sclk_rise = ~sclk_prev_reg & sclk_s;
    assign cs_fall   = cs_prev_reg & ~cs_n_s;
    // a word counts only if exactly the full length arrived
    assign commit    = ~cs_prev_reg & cs_n_s & (cnt_reg == FULL);
    assign waddr     = shift_reg[qdlc_pkg::ADDR_LSB +: qdlc_pkg::ADDR_W];
    assign wdata     = shift_reg[W-1:0];

    // shift on falling edges; the host opens each frame with one
    always_comb begin
        shift_next = shift_reg;
        cnt_next   = cnt_reg;
        sdo_next   = sdo_reg;
        if (cs_fall) begin
            cnt_next = '0;
            sdo_next = shift_reg[qdlc_pkg::WORD_BITS-1];
        end else if (!cs_n_s) begin
            if (sclk_fall) begin
                shift_next = {shift_reg[qdlc_pkg::WORD_BITS-2:0], sdi_s};
                if (cnt_reg != '1) begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
            if (sclk_rise) begin
                sdo_next = shift_reg[qdlc_pkg::WORD_BITS-1];
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shift_reg     <= '0;
            cnt_reg       <= '0;
            sclk_prev_reg <= 1'b1; // idle level, so no false edge after reset
            cs_prev_reg   <= 1'b1;
            sdo_reg       <= 1'b0;
            sdo_oe_reg    <= 1'b0;
        end else begin
            shift_reg     <= shift_next;
            cnt_reg       <= cnt_next;
            sclk_prev_reg <= sclk_s;
            cs_prev_reg   <= cs_n_s;
            sdo_reg       <= sdo_next;
            sdo_oe_reg    <= ~cs_n_s;
        end
    end

    // programmable state
    logic [W-1:0] in_data_reg  [N];
    logic [W-1:0] in_data_next [N];
    logic [C-1:0] zero_reg     [N];
    logic [C-1:0] zero_next    [N];
    logic [C-1:0] gcal_reg     [N];
    logic [C-1:0] gcal_next    [N];
    logic [3:0]   gain_sel_reg;
    logic [3:0]   gain_sel_next;
    logic [3:0]   pd_reg;
    logic [3:0]   pd_next;
    logic [1:0]   gpio_rel_reg;
    logic [1:0]   gpio_rel_next;

    // reset pin wins over any word finishing in the same cycle
    always_comb begin
        gain_sel_next = gain_sel_reg;
        pd_next       = pd_reg;
        gpio_rel_next = gpio_rel_reg;
        for (int i = 0; i < N; i++) begin
            in_data_next[i] = in_data_reg[i];
            zero_next[i]    = zero_reg[i];
            gcal_next[i]    = gcal_reg[i];
        end
        if (!dev_rst_n_s) begin
            gain_sel_next = qdlc_pkg::GAIN_SEL_RST;
            pd_next       = qdlc_pkg::PD_RST;
            gpio_rel_next = qdlc_pkg::GPIO_REL_RST;
            for (int i = 0; i < N; i++) begin
                in_data_next[i] = qdlc_pkg::CODE_RST;
                zero_next[i]    = qdlc_pkg::ZERO_CAL_RST;
                gcal_next[i]    = qdlc_pkg::GAIN_CAL_RST;
            end
        end else if (commit) begin
            if (waddr == qdlc_pkg::ADDR_CTRL) begin
                gain_sel_next = wdata[qdlc_pkg::CTRL_GAIN_LSB +: 4];
                pd_next       = wdata[qdlc_pkg::CTRL_PD_LSB +: 4];
                gpio_rel_next = wdata[qdlc_pkg::CTRL_GPIO_LSB +: 2];
            end
            for (int i = 0; i < N; i++) begin
                if (waddr == qdlc_pkg::ADDR_DATA_BASE + 4'(i)) begin
                    in_data_next[i] = wdata;
                end
                if (waddr == qdlc_pkg::ADDR_ZERO_BASE + 4'(i)) begin
                    zero_next[i] = wdata[C-1:0];
                end
                if (waddr == qdlc_pkg::ADDR_GAIN_BASE + 4'(i)) begin
                    gcal_next[i] = wdata[C-1:0];
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gain_sel_reg <= qdlc_pkg::GAIN_SEL_RST;
            pd_reg       <= qdlc_pkg::PD_RST;
            gpio_rel_reg <= qdlc_pkg::GPIO_REL_RST;
            for (int i = 0; i < N; i++) begin
                in_data_reg[i] <= qdlc_pkg::CODE_RST;
                zero_reg[i]    <= qdlc_pkg::ZERO_CAL_RST;
                gcal_reg[i]    <= qdlc_pkg::GAIN_CAL_RST;
            end
        end else begin
            gain_sel_reg <= gain_sel_next;
            pd_reg       <= pd_next;
            gpio_rel_reg <= gpio_rel_next;
            for (int i = 0; i < N; i++) begin
                in_data_reg[i] <= in_data_next[i];
                zero_reg[i]    <= zero_next[i];
                gcal_reg[i]    <= gcal_next[i];
            end
        end
    end

    // output latches hold ladder codes so the format is fixed at load time
    logic [W-1:0] latch_reg  [N];
    logic [W-1:0] latch_next [N];
    logic [N-1:0] unipolar;

    assign unipolar = {pol_b_s, pol_b_s, pol_a_s, pol_a_s};

    // transparent while load is low; a word written then flows straight on
    always_comb begin
        for (int i = 0; i < N; i++) begin
            latch_next[i] = latch_reg[i];
            if (!dev_rst_n_s) begin
                latch_next[i] = qdlc_pkg::to_ladder(qdlc_pkg::CODE_RST, unipolar[i]);
            end else if (!latch_load_n_n_s) begin
                latch_next[i] = qdlc_pkg::to_ladder(in_data_reg[i], unipolar[i]);
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < N; i++) begin
                latch_reg[i] <= qdlc_pkg::CODE_RST;
            end
        end else begin
            for (int i = 0; i < N; i++) begin
                latch_reg[i] <= latch_next[i];
            end
        end
    end

    // open-drain pins: data is always low, enable pulls the line down
    logic [1:0] gpio_oe_reg;
    logic [1:0] gpio_out_reg;
    logic [1:0] gpio_level_reg;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gpio_oe_reg    <= 2'h0;
            gpio_out_reg   <= 2'h0;
            gpio_level_reg <= 2'h3;
        end else begin
            gpio_oe_reg    <= ~gpio_rel_reg;
            gpio_out_reg   <= 2'h0;
            gpio_level_reg <= gpio_s;
        end
    end

    // per-channel recovery timers
    logic [N-1:0] powered;

    for (genvar g = 0; g < N; g++) begin : g_pd
        qdlc_pd_timer #(
            .CYCLES (PD_RECOVERY_CYCLES)
        ) u_pd (
            .clk_i   (clk_i),
            .rst_n_i (rst_n_i),
            .pd_i    (pd_reg[g]),
            .ready_o (powered[g])
        );
        assign chan_o[g] = '{code:      latch_reg[g],
                             zero_cal:  zero_reg[g],
                             gain_cal:  gcal_reg[g],
                             gain_high: gain_sel_reg[g],
                             powered:   powered[g]};
    end

    assign sdo_o        = sdo_reg;
    assign sdo_oe_o     = sdo_oe_reg;
    assign gpio_o       = gpio_out_reg;
    assign gpio_oe_o    = gpio_oe_reg;
    assign gpio_level_o = gpio_level_reg;

    a_sdo_released_idle: assert property (
        cs_n_s |=> !sdo_oe_o)
        else $error("serial output driven while chip select high");
    a_shift_cs_low: assert property (
        cs_n_s |=> $stable(shift_reg))
        else $error("shift register moved with chip select high");
    a_latch_transparent: assert property (
        (!latch_load_n_n_s && dev_rst_n_s) [*2] |-> latch_reg[1] ==
            qdlc_pkg::to_ladder($past(in_data_reg[1]), $past(pol_a_s)))
        else $error("latch not following input register while load low");
    a_latch_holds_high: assert property (
        $changed(latch_reg[0]) || $changed(latch_reg[3]) |-> $past(!latch_load_n_n_s || !dev_rst_n_s))
        else $error("latch changed without load or reset");
    a_reset_data_latch: assert property (
        !dev_rst_n_s |=> in_data_reg[0] == qdlc_pkg::CODE_RST &&
            latch_reg[2] == qdlc_pkg::to_ladder(qdlc_pkg::CODE_RST, $past(pol_b_s)))
        else $error("reset pin did not clear data and latch");
    a_reset_cal_regs: assert property (
        !dev_rst_n_s |=> zero_reg[2] == qdlc_pkg::ZERO_CAL_RST &&
            gcal_reg[3] == qdlc_pkg::GAIN_CAL_RST)
        else $error("calibration registers not restored");
    a_gpio_pull_low: assert property (
        ##1 (gpio_o == 2'h0) && (gpio_oe_o == ~$past(gpio_rel_reg)))
        else $error("general-purpose pin drive wrong");
    a_group_a_format: assert property (
        (!pol_a_s && !latch_load_n_n_s && dev_rst_n_s) |=>
            latch_reg[0][W-1] == ~$past(in_data_reg[0][W-1]))
        else $error("group A bipolar code not offset");
    a_group_b_format: assert property (
        (pol_b_s && !latch_load_n_n_s && dev_rst_n_s) |=> latch_reg[3] == $past(in_data_reg[3]))
        else $error("group B unipolar code altered");
    a_gain_default: assert property (
        !dev_rst_n_s |=> gain_sel_reg == qdlc_pkg::GAIN_SEL_RST)
        else $error("gain select not defaulted");
endmodule : qdlc_top

// ==== dv/qdlc_host_model.sv ====
// host-side serial master model: chip select, serial clock and data
`timescale 1ns/1ps
module qdlc_host_model #(
    parameter int HALF_NS = 80
) (
    output logic cs_n_o,
    output logic sclk_o,
    output logic sdi_o
);
    // idle: deselected, clock parked high so the first edge of a frame falls
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b1;
        sdi_o  = 1'b0;
    end

    // shift nbits of word msb first, one bit taken per falling edge
    task automatic send(input logic [23:0] word, input int nbits);
        int i;
        cs_n_o = 1'b0;
        for (i = 23; i > 23 - nbits; i--) begin
            sdi_o = word[i];
            #(HALF_NS);
            sclk_o = 1'b0;
            #(HALF_NS);
            sclk_o = 1'b1;
        end
        #(HALF_NS);
        cs_n_o = 1'b1;
        // no pull on the data line: show the inverse rather than a stale bit
        sdi_o  = ~sdi_o;
    endtask : send
endmodule : qdlc_host_model

// ==== dv/test_quad_dac_load_control.sv ====
// self-checking bench for the quad converter load control
`timescale 1ns/1ps
module test_quad_dac_load_control;
    logic                       clk;
    logic                       rst_n;
    logic                       cs_n;
    logic                       sclk;
    logic                       sdi;
    logic                       sdo;
    logic                       sdo_oe;
    logic                       load_n;
    logic                       dev_rst_n;
    logic                       pol_a;
    logic                       pol_b;
    logic [1:0]                 gpio_ext;
    logic [1:0]                 gpio_out;
    logic [1:0]                 gpio_oe;
    logic [1:0]                 gpio_level;
    logic [1:0]                 gpio_pin;
    qdlc_pkg::qdlc_chan_t [3:0] chan;
    logic [15:0]                wdata [4];
    int                         fail_count;
    int                         tests_run;
    int                         cs_hi_cnt;
    int                         i;
    int                         n;

    // open-drain wire: device pulls low, otherwise pull-up or external driver
    assign gpio_pin = (gpio_oe & gpio_out) | (~gpio_oe & gpio_ext);

    qdlc_host_model host (.cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi));

    qdlc_top #(.PD_RECOVERY_CYCLES(20)) uut (
        .clk_i                     (clk),
        .rst_n_i                   (rst_n),
        .cs_n_i                    (cs_n),
        .sclk_i                    (sclk),
        .sdi_i                     (sdi),
        .sdo_o                     (sdo),
        .sdo_oe_o                  (sdo_oe),
        .latch_load_n_i            (load_n),
        .dev_reset_n_i             (dev_rst_n),
        .polarity_select_group_a_i (pol_a),
        .polarity_select_group_b_i (pol_b),
        .gpio_i                    (gpio_pin),
        .gpio_o                    (gpio_out),
        .gpio_oe_o                 (gpio_oe),
        .gpio_level_o              (gpio_level),
        .chan_o                    (chan)
    );

    initial clk = 1'b0;
    always #2 clk = ~clk;

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    // one whole frame, then enough cycles for commit and latch to settle
    task automatic wr(input logic [3:0] addr, input logic [15:0] data);
        @(negedge clk);
        host.send({4'h0, addr, data}, 24);
        if (addr[3:2] == 2'b01) wdata[addr[1:0]] = data;
        repeat (8) @(negedge clk);
    endtask : wr

    // expected ladder code from the written word and the group's mode pin
    function automatic logic [15:0] exp_code(input int ch);
        logic bip;
        bip = (ch < 2) ? ~pol_a : ~pol_b;
        exp_code = bip ? (wdata[ch] ^ 16'h8000) : wdata[ch];
    endfunction : exp_code

    // output must be released once the host has been deselected for more than four cycles
    always @(negedge clk) begin
        cs_hi_cnt <= cs_n ? cs_hi_cnt + 1 : 0;
        if (cs_hi_cnt > 4) check({15'h0000, sdo_oe}, 16'h0000, "sdo released");
    end

    initial begin
        rst_n = 1'b0;
        load_n = 1'b1;
        dev_rst_n = 1'b1;
        pol_a = 1'b1;
        pol_b = 1'b1;
        gpio_ext = 2'b11;
        fail_count = 0;
        tests_run = 0;
        cs_hi_cnt = 0;
        for (i = 0; i < 4; i++) wdata[i] = 16'h0000;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        // defaults after power-on reset
        for (i = 0; i < 4; i++) begin
            check(chan[i].code, 16'h0000, "code at reset");
            check({8'h00, chan[i].zero_cal}, 16'h0000, "zero cal at reset");
            check({8'h00, chan[i].gain_cal}, 16'h0080, "gain cal at reset");
            check({14'h0000, chan[i].gain_high, chan[i].powered}, 16'h0003, "gain sel");
        end
        check({14'h0000, gpio_oe}, 16'h0000, "gpio released at reset");
        // load high: input registers fill while latches hold
        for (i = 0; i < 4; i++) wr(4'(qdlc_pkg::ADDR_DATA_BASE + i), 16'(16'h1111 * (i + 1)));
        for (i = 0; i < 4; i++) check(chan[i].code, 16'h0000, "latch holds");
        // load low: all four latches follow in the same cycle
        load_n = 1'b0;
        for (n = 0; n < 10 && chan[0].code === 16'h0000; n++) @(negedge clk);
        for (i = 0; i < 4; i++) check(chan[i].code, exp_code(i), "joint update");
        // group modes switch the code format per pair of channels
        pol_a = 1'b0;
        repeat (6) @(negedge clk);
        for (i = 0; i < 4; i++) check(chan[i].code, exp_code(i), "group a bipolar");
        pol_b = 1'b0;
        repeat (6) @(negedge clk);
        for (i = 0; i < 4; i++) check(chan[i].code, exp_code(i), "group b bipolar");
        // load tied low: a write reaches its latch with no strobe
        wr(4'(qdlc_pkg::ADDR_DATA_BASE + 1), 16'hFFFE);
        check(chan[1].code, 16'h7FFE, "twos complement word");
        // short frame is dropped; output driven while selected
        @(negedge clk);
        fork
            host.send({4'h0, qdlc_pkg::ADDR_DATA_BASE, 16'hABCD}, 23);
            begin
                repeat (40) @(negedge clk);
                check({15'h0000, sdo_oe}, 16'h0001, "sdo driven in frame");
                // previous word 05FFFE moves out msb first: after rise 5 its bit 18 shows
                repeat (180) @(negedge clk);
                check({15'h0000, sdo}, 16'h0001, "sdo echoes shift");
            end
        join
        repeat (8) @(negedge clk);
        check(chan[0].code, exp_code(0), "short frame ignored");
        // control: gains low, channel 2 down, gpio 1 pulled low
        wr(qdlc_pkg::ADDR_CTRL, 16'h0140);
        for (i = 0; i < 4; i++) check({15'h0000, chan[i].gain_high}, 16'h0000, "gain cleared");
        check({15'h0000, chan[2].powered}, 16'h0000, "channel down");
        check({12'h000, gpio_oe, gpio_out}, 16'h0008, "gpio pulls low");
        gpio_ext = 2'b10;
        repeat (5) @(negedge clk);
        check({14'h0000, gpio_level}, 16'h0000, "gpio input low");
        gpio_ext = 2'b11;
        repeat (5) @(negedge clk);
        check({14'h0000, gpio_level}, 16'h0001, "open drain wins");
        // power-up again: ready only after the recovery count
        wr(qdlc_pkg::ADDR_CTRL, 16'h0300);
        check({15'h0000, chan[2].powered}, 16'h0000, "still recovering");
        for (n = 0; n < 40 && chan[2].powered !== 1'b1; n++) @(negedge clk);
        check({15'h0000, chan[2].powered}, 16'h0001, "recovered");
        check(16'(n >= 8), 16'h0001, "recovery not early");
        // device reset pin with calibration changed and mixed modes
        wr(4'(qdlc_pkg::ADDR_ZERO_BASE + 3), 16'h0055);
        wr(4'(qdlc_pkg::ADDR_GAIN_BASE + 3), 16'h00AA);
        check({chan[3].zero_cal, chan[3].gain_cal}, 16'h55AA, "cal written");
        pol_b = 1'b1;
        dev_rst_n = 1'b0;
        repeat (6) @(negedge clk);
        for (i = 0; i < 4; i++) wdata[i] = 16'h0000;
        for (i = 0; i < 4; i++) check(chan[i].code, exp_code(i), "reset by mode");
        check({chan[3].zero_cal, chan[3].gain_cal}, 16'h0080, "cal defaults");
        for (i = 0; i < 4; i++) check({15'h0000, chan[i].gain_high}, 16'h0001, "gain high");
        dev_rst_n = 1'b1;
        repeat (6) @(negedge clk);
        tally_and_finish();
    end
endmodule : test_quad_dac_load_control
